// ### pkg/twl_pkg.sv
// Function
// - Each serial clock rising edge shifts the data bit into a 24-bit register.
// - Load strobe rising copies the shift register into the selected latch.
// - Chip enable low powers down; high enables subject to latch power-down bit.
// - Each overflow rising edge lowers receive gain by 6 dB, or to code 0 if the gain is below 6 dB.
// - Status output shows lock, divided oscillator or divided reference.
// - Three select bits in the control latch choose the status source.
// - Lock rises after 3 or 5 good cycles below 15 ns; falls above 25 ns.
// - Oscillator latch update starts band selection lasting five detector cycles.
`default_nettype none
package twl_pkg;
  localparam int SR_W = 24;
  localparam int CTL_W = 2;
  localparam int NUM_LATCH = 4;
  localparam logic [1:0] LAT_CTRL = 2'h0;
  localparam logic [1:0] LAT_TX = 2'h1;
  localparam logic [1:0] LAT_RXCAL = 2'h2;
  localparam logic [1:0] LAT_LO = 2'h3;
  localparam int MUX_LSB = 2;
  localparam int PD_BIT = 5;
  localparam int GAIN_LSB = 2;
  localparam int LDP_BIT = 2;
  localparam int GAIN_W = 3;
  localparam int GAIN_STEP_DB = 3;
  localparam int OVF_DROP_DB = 6;
  localparam logic [GAIN_W-1:0] OVF_STEP = GAIN_W'(OVF_DROP_DB / GAIN_STEP_DB);
  localparam int ERR_W = 8;
  localparam logic [ERR_W-1:0] LOCK_ERR_NS = 8'h0F;
  localparam logic [ERR_W-1:0] UNLOCK_ERR_NS = 8'h19;
  localparam logic [2:0] LOCK_CNT_LO = 3'h3;
  localparam logic [2:0] LOCK_CNT_HI = 3'h5;
  localparam logic [2:0] BAND_SEL_PD = 3'h5;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_LAT0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h14;
  localparam logic CFG_RST = 1'h1;
  localparam int ST_LOCK = 0;
  localparam int ST_BAND = 1;
  localparam int ST_PWR = 2;
  localparam int ST_GAIN_LSB = 4;
  typedef enum logic [2:0] {
    TWL_MUX_OFF = 3'b000,
    TWL_MUX_LOCK = 3'b001,
    TWL_MUX_OSC = 3'b010,
    TWL_MUX_REF = 3'b011
  } twl_mux_type;
  typedef enum logic [0:0] {
    TWL_UNLOCKED = 1'b0,
    TWL_LOCKED = 1'b1
  } twl_lock_type;
endpackage
`default_nettype wire

// ### pkg/twl_load_if.sv
`timescale 1ns/10ps
`default_nettype none
interface twl_load_if;
  logic load;
  logic [twl_pkg::SR_W-1:0] word;
  modport src(output load, output word);
  modport dst(input load, input word);
endinterface
`default_nettype wire

// ### design/twl_serial_rx.sv
`timescale 1ns/10ps
`default_nettype none
module twl_serial_rx (
  input wire logic i_mclk, // System clock.
  input wire logic i_rst, // Synchronous reset.
  input wire logic i_clk_en, // Freezes state when low.
  input wire logic i_port_en, // Loads ignored when low.
  input wire logic i_sclk, // Serial clock pin.
  input wire logic i_prog_serial_in, // Serial data pin.
  input wire logic i_load_strobe, // Load strobe pin.
  twl_load_if.src ld // Load event towards latches.
);
  logic [2:0] s1;
  logic [2:0] s2;
  logic [1:0] s3;
  logic [twl_pkg::SR_W-1:0] sr;
  logic sclk_rise;
  logic le_rise;

  // -----------------------------------------------
  // Pin synchronisers and edge detection.
  // -----------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1 <= 3'h0;
      s2 <= 3'h0;
      s3 <= 2'h0;
    end else if (i_clk_en) begin
      s1 <= {i_load_strobe, i_prog_serial_in, i_sclk};
      s2 <= s1;
      s3 <= {s2[2], s2[0]};
    end
  end
  assign sclk_rise = s2[0] & ~s3[0];
  assign le_rise = s2[2] & ~s3[1];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sr <= '0;
    end else if (i_clk_en && sclk_rise) begin
      sr <= {sr[twl_pkg::SR_W-2:0], s2[1]};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ld.load <= 1'b0;
      ld.word <= '0;
    end else if (i_clk_en) begin
      ld.load <= le_rise & i_port_en;
      if (le_rise) begin
        ld.word <= sr;
      end
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_shift;
    i_clk_en && sclk_rise |=> sr == {$past(sr[twl_pkg::SR_W-2:0]), $past(s2[1])};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register missed a bit");
  property p_load;
    i_clk_en && le_rise && i_port_en |=> ld.load && ld.word == $past(sr);
  endproperty
  a_load: assert property (p_load) else $error("load strobe edge not passed on");
endmodule
`default_nettype wire

// ### design/twl_lock_detect.sv
`timescale 1ns/10ps
`default_nettype none
module twl_lock_detect (
  input wire logic i_mclk, // System clock.
  input wire logic i_rst, // Synchronous reset.
  input wire logic i_clk_en, // Freezes state when low.
  input wire logic i_pd_tick, // One pulse per detector cycle.
  input wire logic [twl_pkg::ERR_W-1:0] i_phase_err_ns, // Phase error in ns.
  input wire logic i_precision, // Lock precision bit.
  output logic o_lock // Digital lock, from a flop.
);
  twl_pkg::twl_lock_type state;
  logic [2:0] cnt;
  logic [2:0] need;
  logic good;
  logic bad;

  assign need = i_precision ? twl_pkg::LOCK_CNT_HI : twl_pkg::LOCK_CNT_LO;
  assign good = i_phase_err_ns < twl_pkg::LOCK_ERR_NS;
  assign bad = i_phase_err_ns > twl_pkg::UNLOCK_ERR_NS;
  assign o_lock = (state == twl_pkg::TWL_LOCKED);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= twl_pkg::TWL_UNLOCKED;
      cnt <= 3'h0;
    end else if (i_clk_en && i_pd_tick) begin
      unique case (state)
        twl_pkg::TWL_UNLOCKED: begin
          if (!good) begin
            cnt <= 3'h0;
          end else if (cnt + 3'h1 >= need) begin
            cnt <= 3'h0;
            state <= twl_pkg::TWL_LOCKED;
          end else begin
            cnt <= cnt + 3'h1;
          end
        end
        twl_pkg::TWL_LOCKED: begin
          if (bad) begin
            state <= twl_pkg::TWL_UNLOCKED;
          end
        end
      endcase
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_lock_rise;
    $rose(o_lock) |-> $past(good) && $past(cnt) == $past(need) - 3'h1;
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose too soon");
  property p_lock_fall;
    o_lock && i_clk_en && i_pd_tick && bad |=> !o_lock;
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock kept past large error");
  property p_lock_hold;
    o_lock && !(i_clk_en && i_pd_tick && bad) |=> o_lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped without cause");
endmodule
`default_nettype wire

// ### design/twl_top.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module twl_top (
  input wire logic i_mclk, // System clock, 100 MHz.
  input wire logic i_rst, // Synchronous reset, high.
  input wire logic i_clk_en, // Freezes all state when low.
  input wire logic i_sclk, // Serial clock pin.
  input wire logic i_prog_serial_in, // Serial data pin.
  input wire logic i_load_strobe, // Load strobe pin.
  input wire logic i_chip_en, // Chip enable pin.
  input wire logic i_overflow_in, // Overflow pin.
  input wire logic i_osc_div, // Divided oscillator clock.
  input wire logic i_ref_div, // Divided reference clock.
  input wire logic i_pd_tick, // Detector cycle pulse.
  input wire logic [twl_pkg::ERR_W-1:0] i_phase_err_ns, // Phase error in ns.
  input wire logic i_psel, // APB select.
  input wire logic i_penable, // APB enable.
  input wire logic i_pwrite, // APB direction.
  input wire logic [twl_pkg::ADDR_W-1:0] i_paddr, // APB byte address.
  input wire logic [31:0] i_pwdata, // APB write data.
  output logic [31:0] o_prdata, // APB read data.
  output logic o_pready, // APB ready.
  output logic o_pslverr, // APB error.
  output logic o_status_mux_out, // Multiplexed status.
  output logic o_powered, // Device enabled.
  output logic [twl_pkg::GAIN_W-1:0] o_rx_gain, // Receive gain code.
  output logic o_band_sel // Band selection running.
);
  twl_load_if ld ();
  logic [twl_pkg::SR_W-1:0] lat [twl_pkg::NUM_LATCH];
  logic [3:0] a_s1;
  logic [3:0] a_s2;
  logic ovf_s3;
  logic pwr_q;
  logic port_en;
  logic lock;
  logic ovf_rise;
  logic [2:0] bs_cnt;
  logic [2:0] next_bs_cnt;
  logic bs_trig;
  logic next_mux;
  logic [twl_pkg::GAIN_W-1:0] next_gain;
  logic [twl_pkg::GAIN_W-1:0] gain_base;
  logic [31:0] rd_data;
  logic apb_setup;
  logic apb_done;
  twl_pkg::twl_mux_type mux_sel;

  // -----------------------------------------------
  // Field decoding.
  // -----------------------------------------------
  function automatic logic [2:0] fld3(input logic [twl_pkg::SR_W-1:0] w, input int lsb);
    fld3 = w[lsb +: 3];
  endfunction

  function automatic logic reg_known(input logic [twl_pkg::ADDR_W-1:0] a);
    reg_known = (a < twl_pkg::OFF_STAT && a[1:0] == 2'h0) || a == twl_pkg::OFF_STAT ||
      a == twl_pkg::OFF_CFG;
  endfunction

  // -----------------------------------------------
  // Serial front end and lock detection.
  // -----------------------------------------------
  twl_serial_rx u_rx (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_port_en(port_en),
    .i_sclk(i_sclk),
    .i_prog_serial_in(i_prog_serial_in),
    .i_load_strobe(i_load_strobe),
    .ld(ld.src)
  );

  twl_lock_detect u_lock (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_pd_tick(i_pd_tick),
    .i_phase_err_ns(i_phase_err_ns),
    .i_precision(lat[twl_pkg::LAT_LO][twl_pkg::LDP_BIT]),
    .o_lock(lock)
  );

  // -----------------------------------------------
  // Synchronisers for the other asynchronous pins.
  // -----------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          a_s1[gi] <= 1'b0;
          a_s2[gi] <= 1'b0;
        end else if (i_clk_en) begin
          a_s1[gi] <= (gi == 0) ? i_chip_en : (gi == 1) ? i_overflow_in :
            (gi == 2) ? i_osc_div : i_ref_div;
          a_s2[gi] <= a_s1[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ovf_s3 <= 1'b0;
    end else if (i_clk_en) begin
      ovf_s3 <= a_s2[1];
    end
  end
  assign ovf_rise = a_s2[1] & ~ovf_s3;

  // -----------------------------------------------
  // Latches.
  // -----------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int i = 0; i < twl_pkg::NUM_LATCH; i++) begin
        lat[i] <= '0;
      end
    end else if (i_clk_en && ld.load) begin
      lat[ld.word[twl_pkg::CTL_W-1:0]] <= ld.word;
    end
  end

  // -----------------------------------------------
  // Power control.
  // -----------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_powered <= 1'b0;
      pwr_q <= 1'b0;
    end else if (i_clk_en) begin
      o_powered <= a_s2[0] & ~lat[twl_pkg::LAT_CTRL][twl_pkg::PD_BIT];
      pwr_q <= o_powered;
    end
  end

  // -----------------------------------------------
  // Receive gain with overflow step-down.
  // -----------------------------------------------
  always_comb begin
    gain_base = o_rx_gain;
    if (ld.load && ld.word[twl_pkg::CTL_W-1:0] == twl_pkg::LAT_RXCAL) begin
      gain_base = fld3(ld.word, twl_pkg::GAIN_LSB);
    end
    next_gain = gain_base;
    if (ovf_rise) begin
      next_gain = (gain_base > twl_pkg::OVF_STEP) ? gain_base - twl_pkg::OVF_STEP : '0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rx_gain <= '0;
    end else if (i_clk_en) begin
      o_rx_gain <= next_gain;
    end
  end

  // -----------------------------------------------
  // Band selection after an oscillator latch update.
  // -----------------------------------------------
  assign bs_trig = (ld.load && ld.word[twl_pkg::CTL_W-1:0] == twl_pkg::LAT_LO) ||
    (o_powered && !pwr_q);

  always_comb begin
    next_bs_cnt = bs_cnt;
    if (bs_trig) begin
      next_bs_cnt = twl_pkg::BAND_SEL_PD;
    end else if (i_pd_tick && bs_cnt != 3'h0) begin
      next_bs_cnt = bs_cnt - 3'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bs_cnt <= 3'h0;
      o_band_sel <= 1'b0;
    end else if (i_clk_en) begin
      bs_cnt <= next_bs_cnt;
      o_band_sel <= (next_bs_cnt != 3'h0);
    end
  end

  // -----------------------------------------------
  // Status multiplexer.
  // -----------------------------------------------
  assign mux_sel = twl_pkg::twl_mux_type'(fld3(lat[twl_pkg::LAT_CTRL], twl_pkg::MUX_LSB));

  always_comb begin
    unique case (mux_sel)
      twl_pkg::TWL_MUX_OFF: next_mux = 1'b0;
      twl_pkg::TWL_MUX_LOCK: next_mux = lock;
      twl_pkg::TWL_MUX_OSC: next_mux = a_s2[2];
      twl_pkg::TWL_MUX_REF: next_mux = a_s2[3];
      default: next_mux = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_status_mux_out <= 1'b0;
    end else if (i_clk_en) begin
      o_status_mux_out <= next_mux;
    end
  end

  // -----------------------------------------------
  // APB slave.
  // -----------------------------------------------
  assign apb_setup = i_psel && i_penable && !o_pready;
  assign apb_done = i_psel && i_penable && o_pready;

  always_comb begin
    rd_data = 32'h0;
    if (i_paddr < twl_pkg::OFF_STAT) begin
      rd_data[twl_pkg::SR_W-1:0] = lat[i_paddr[3:2]];
    end else if (i_paddr == twl_pkg::OFF_STAT) begin
      rd_data[twl_pkg::ST_LOCK] = lock;
      rd_data[twl_pkg::ST_BAND] = o_band_sel;
      rd_data[twl_pkg::ST_PWR] = o_powered;
      rd_data[twl_pkg::ST_GAIN_LSB +: twl_pkg::GAIN_W] = o_rx_gain;
    end else if (i_paddr == twl_pkg::OFF_CFG) begin
      rd_data[0] = port_en;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      o_pready <= apb_setup;
      o_pslverr <= apb_setup && (!reg_known(i_paddr) ||
        (i_pwrite && i_paddr != twl_pkg::OFF_CFG));
      o_prdata <= (apb_setup && !i_pwrite && reg_known(i_paddr)) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      port_en <= twl_pkg::CFG_RST;
    end else if (i_clk_en && apb_done && i_pwrite && i_paddr == twl_pkg::OFF_CFG) begin
      port_en <= i_pwdata[0];
    end
  end

  // -----------------------------------------------
  // Checks.
  // -----------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_latch_load;
    i_clk_en && ld.load |=> lat[$past(ld.word[1:0])] == $past(ld.word);
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_power;
    i_clk_en |=> o_powered == ($past(a_s2[0]) && !$past(lat[0][twl_pkg::PD_BIT]));
  endproperty
  a_power: assert property (p_power) else $error("power state wrong");

  property p_ovf_drop;
    i_clk_en && ovf_rise && !ld.load && o_rx_gain > twl_pkg::OVF_STEP
      |=> o_rx_gain == $past(o_rx_gain) - twl_pkg::OVF_STEP;
  endproperty
  a_ovf_drop: assert property (p_ovf_drop) else $error("gain not lowered by 6 dB");

  property p_mux_lock;
    i_clk_en && mux_sel == twl_pkg::TWL_MUX_LOCK |=> o_status_mux_out == $past(lock);
  endproperty
  a_mux_lock: assert property (p_mux_lock) else $error("status not showing lock");

  property p_mux_ref;
    i_clk_en && mux_sel == twl_pkg::TWL_MUX_REF |=> o_status_mux_out == $past(a_s2[3]);
  endproperty
  a_mux_ref: assert property (p_mux_ref) else $error("status not showing reference");

  sequence s_bs_start;
    i_clk_en && bs_trig;
  endsequence
  sequence s_bs_quiet;
    i_clk_en && !bs_trig && !i_pd_tick;
  endsequence
  property p_bs_start;
    s_bs_start |=> o_band_sel && bs_cnt == twl_pkg::BAND_SEL_PD;
  endproperty
  a_bs_start: assert property (p_bs_start) else $error("band select not started");
  property p_bs_hold;
    o_band_sel ##0 s_bs_quiet |=> o_band_sel && $stable(bs_cnt);
  endproperty
  a_bs_hold: assert property (p_bs_hold) else $error("band select ended early");
  property p_bs_end;
    i_clk_en && !bs_trig && i_pd_tick && bs_cnt == 3'h1 |=> !o_band_sel;
  endproperty
  a_bs_end: assert property (p_bs_end) else $error("band select ran too long");

  property p_apb_ready;
    apb_setup && i_clk_en |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready not one cycle");
endmodule
`default_nettype wire

// ### verif/twl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module twl_host_model (
  input wire logic i_mclk, // System clock.
  output logic o_sclk, // Serial clock, low between words.
  output logic o_prog_serial_in, // Serial data.
  output logic o_load_strobe // Load strobe.
);
  initial begin
    o_sclk = 1'b0;
    o_prog_serial_in = 1'b0;
    o_load_strobe = 1'b0;
  end

  // ----------------------------------------
  // Word transfer
  // ----------------------------------------
  // Shifts a word out, then pulses the strobe; half is the clock half period in cycles.
  // The data line shows the inverse of the last bit once the word is over.
  task automatic send(input logic [twl_pkg::SR_W-1:0] w, input int half);
    for (int i = twl_pkg::SR_W - 1; i >= 0; i--) begin
      o_prog_serial_in <= w[i];
      repeat (half) @(posedge i_mclk);
      o_sclk <= 1'b1;
      repeat (half) @(posedge i_mclk);
      o_sclk <= 1'b0;
    end
    repeat (half) @(posedge i_mclk);
    o_load_strobe <= 1'b1;
    o_prog_serial_in <= ~w[0];
    repeat (half) @(posedge i_mclk);
    o_load_strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/three_wire_latch_loader_bench.sv
`timescale 1ns/10ps
`default_nettype none
module three_wire_latch_loader_bench;
  logic clk, rst, chip_en, ovf, osc, ref_d, tick, psel, penable, pwrite, pready, pslverr;
  logic mux_out, powered, band, sclk, prog_serial_in, strobe, er, clk_en;
  logic [twl_pkg::ERR_W-1:0] err_ns;
  logic [twl_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [twl_pkg::GAIN_W-1:0] gain;
  logic [23:0] lat [4];
  int failures = 0;
  int checked = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  twl_host_model i_host (.i_mclk(clk), .o_sclk(sclk), .o_prog_serial_in(prog_serial_in),
    .o_load_strobe(strobe));

  twl_top i_dut (.i_mclk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_sclk(sclk),
    .i_prog_serial_in(prog_serial_in), .i_load_strobe(strobe), .i_chip_en(chip_en),
    .i_overflow_in(ovf), .i_osc_div(osc), .i_ref_div(ref_d), .i_pd_tick(tick),
    .i_phase_err_ns(err_ns), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_status_mux_out(mux_out), .o_powered(powered),
    .o_rx_gain(gain), .o_band_sel(band));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [twl_pkg::ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b0, a, 32'h0);
    check(nm, d, rd);
    check("read_err", {31'h0, e}, {31'h0, er});
  endtask

  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    check("write_err", {31'h0, e}, {31'h0, er});
  endtask

  task automatic load(input logic [23:0] w, input int half);
    i_host.send(w, half);
    repeat (10) @(posedge clk);
  endtask

  task automatic tk(input logic [7:0] e);
    err_ns <= e;
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic lockchk(input logic exp);
    apb(1'b0, twl_pkg::OFF_STAT, 32'h0);
    check("lock", {31'h0, exp}, {31'h0, rd[twl_pkg::ST_LOCK]});
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    chip_en = 1'b1;
    clk_en = 1'b1;
    ovf = 1'b0;
    osc = 1'b0;
    ref_d = 1'b0;
    tick = 1'b0;
    err_ns = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("cfg", twl_pkg::OFF_CFG, 32'h1, 1'b0);
    rdchk("unmapped", 8'h18, 32'h0, 1'b1);
    rdchk("unaligned", 8'h05, 32'h0, 1'b1);
    wrchk(twl_pkg::OFF_LAT0, 32'hFFFFFFFF, 1'b1);
    wrchk(twl_pkg::OFF_STAT, 32'hFFFFFFFF, 1'b1);
    for (int k = 0; k < 4; k++) begin
      lat[k] = {8'hC3, 8'h5A, 6'(k * 9 + 5), 2'(k)};
      load(lat[k], (k % 2 == 1) ? 3 : 8);
      rdchk("latch", twl_pkg::OFF_LAT0 + 8'(4 * k), {8'h0, lat[k]}, 1'b0);
    end
    rdchk("latch0_kept", twl_pkg::OFF_LAT0, {8'h0, lat[0]}, 1'b0);
    wrchk(twl_pkg::OFF_CFG, 32'h0, 1'b0);
    load(24'hABCDE1, 8);
    rdchk("latch_off", 8'h04, {8'h0, lat[1]}, 1'b0);
    wrchk(twl_pkg::OFF_CFG, 32'h1, 1'b0);
    load(24'h000000, 8);
    check("powered", 32'h1, {31'h0, powered});
    chip_en <= 1'b0;
    repeat (8) @(posedge clk);
    check("powered_ce", 32'h0, {31'h0, powered});
    chip_en <= 1'b1;
    load(24'h000020, 8);
    check("powered_pd", 32'h0, {31'h0, powered});
    load(24'h000000, 8);
    check("powered_on", 32'h1, {31'h0, powered});
    check("band_pwr", 32'h1, {31'h0, band});
    for (int i = 0; i < 5; i++) tk(8'h1E);
    check("band_pwr_end", 32'h0, {31'h0, band});
    load(24'h00001E, 8);
    check("gain", 32'h7, {29'h0, gain});
    clk_en <= 1'b0;
    ovf <= 1'b1;
    repeat (6) @(posedge clk);
    ovf <= 1'b0;
    repeat (6) @(posedge clk);
    clk_en <= 1'b1;
    repeat (6) @(posedge clk);
    check("gain_frozen", 32'h7, {29'h0, gain});
    for (int g = 5; g >= -1; g -= 2) begin
      ovf <= 1'b1;
      repeat (6) @(posedge clk);
      ovf <= 1'b0;
      repeat (6) @(posedge clk);
      check("gain_drop", (g < 0) ? 32'h0 : 32'(g), {29'h0, gain});
    end
    load(24'h000003, 8);
    check("band_on", 32'h1, {31'h0, band});
    tk(8'h05);
    tk(8'h05);
    lockchk(1'b0);
    tk(8'h05);
    lockchk(1'b1);
    tk(8'h14);
    check("band_run", 32'h1, {31'h0, band});
    tk(8'h14);
    check("band_end", 32'h0, {31'h0, band});
    lockchk(1'b1);
    tk(8'h1E);
    lockchk(1'b0);
    load(24'h000007, 3);
    for (int i = 0; i < 4; i++) tk(8'h05);
    lockchk(1'b0);
    tk(8'h05);
    lockchk(1'b1);
    ref_d <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      load({19'h0, 3'(s), 2'h0}, 8);
      check("mux", (s == 1 || s == 3) ? 32'h1 : 32'h0, {31'h0, mux_out});
    end
    osc <= 1'b1;
    ref_d <= 1'b0;
    load(24'h000008, 8);
    check("mux_osc", 32'h1, {31'h0, mux_out});
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
